// ---- dchp_regs.svh ----
// Constants for the host phase protocol engine of the disk controller.
// Assumes a 40 MHz system clock; included by its bare name.
`ifndef DCHP_REGS_SVH
`define DCHP_REGS_SVH
`define DCHP_MSR_REQ_BIT        7
`define DCHP_MSR_DIR_BIT        6
`define DCHP_MSR_NDMA_BIT       5
`define DCHP_MSR_BUSY_BIT       4
`define DCHP_CLK_MHZ            40
`define DCHP_REQ_DLY_FAST_US    12
`define DCHP_REQ_DLY_SLOW_US    24
`define DCHP_REQ_DLY_FAST_CYC   (`DCHP_REQ_DLY_FAST_US * `DCHP_CLK_MHZ)
`define DCHP_REQ_DLY_SLOW_CYC   (`DCHP_REQ_DLY_SLOW_US * `DCHP_CLK_MHZ)
`define DCHP_BYTE_PERIOD_US     13
`define DCHP_BYTE_PERIOD_CYC    (`DCHP_BYTE_PERIOD_US * `DCHP_CLK_MHZ)
`define DCHP_OP_READ_DATA       5'h06
`define DCHP_OP_WRITE_DATA      5'h05
`define DCHP_OP_FORMAT          5'h0D
`define DCHP_OP_RECAL           5'h07
`define DCHP_READ_DATA_PARAMS   4'h9
`define DCHP_FORMAT_PARAMS      4'h6
`define DCHP_RECAL_PARAMS       4'h2
`define DCHP_RW_RESULTS         3'h7
`define DCHP_RECAL_RESULTS      3'h2
`define DCHP_ST0_RESET          8'h00
`define DCHP_ST0_INVALID        8'h80
`define DCHP_ST0_SEEK_END       8'h20
`define DCHP_FILL_BYTE_RESET    8'h00
`endif

// ---- dchp_pkg.sv ----
// Types shared by the host phase protocol engine.
// Assumes dchp_regs.svh supplies the numeric constants.
package dchp_pkg;
    typedef enum {DCHP_CMD, DCHP_EXEC, DCHP_RES} dchp_phase_e;
    typedef struct packed {
        logic       req;
        logic       dir;
        logic       ndma;
        logic       busy;
        logic [3:0] drv_busy;
    } dchp_msr_s;
    typedef struct packed {
        logic       sel_n;
        logic       rd_n;
        logic       wr_n;
        logic       a0;
    } dchp_hbus_s;
endpackage

// ---- dchp_engine.sv ----
// Command/execution/result phase engine with processor handshakes; every command sets polled mode, so no DMA request is raised.
// Assumes strobes come from outside the clock domain; the drive side is
// modelled by a byte pacer and a fill pattern.
`timescale 1ns/1ps
`default_nettype none
`include "dchp_regs.svh"

// Overview of operation
// - Request flag held low 12 or 24 us after each data register access.
// - Each valid command runs command, execution, then result phase; an invalid opcode goes straight to result.
// - Non-DMA drive read raises interrupt per available byte.
// - Non-DMA read strobe outputs byte and clears interrupt.
// - Request flag mirrors interrupt, one byte per 13 us.
// - Write commands clear interrupt by write strobe.
// - Transfer continues until terminal count.
// - DMA mode: no execution interrupts, DMA request per byte; every command here sets ndma_r, so DMA mode is never entered.
// - DMA request drops as soon as acknowledge goes low.
// - Terminal count ends execution and raises result interrupt.
// - First result read clears the result interrupt.
// - All result bytes must be read before a new command.
// - Main status always readable; status bytes only in result phase.
// - Recalibrate decoded with drive byte, head retracts to cylinder 0.
// - Format takes size, count, gap, fill, writes one track.
// - Last command byte starts execution; last result byte ends command.
// - Terminal count aborts any running command except recalibrate, whose execution branch wins.
// - Bit 7 request, bit 6 direction toward processor.
module dchp_engine
    import dchp_pkg::*;
#(
    parameter int SYNC_STAGES = 3
)(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       SLOW_CLOCK_MODE,
    input  wire logic       CS_N,
    input  wire logic       RD_N,
    input  wire logic       WR_N,
    input  wire logic       REGISTER_SELECT,
    input  wire logic [7:0] DB_IN,
    output logic      [7:0] DB_OUT,
    output logic            DB_OE,
    output logic            INT_REQ,
    output logic            DMA_REQUEST,
    input  wire logic       DMA_ACKNOWLEDGE_N,
    input  wire logic       TERMINAL_COUNT,
    output logic      [7:0] MAIN_STATUS,
    output logic      [1:0] DRIVE_SELECT,
    output logic            HEAD_RETRACT,
    output logic            TRACK_WRITE,
    output logic      [7:0] WRITE_BYTE
);

    if (SYNC_STAGES != 3) $error("SYNC_STAGES must be 3");

    // Three-stage sync; only stages 2 and 3 are compared
    logic [5:0] s1_r, s2_r, s3_r;
    logic [5:0] ps_r;
    logic [5:0] raw;
    assign raw = {CS_N, RD_N, WR_N, REGISTER_SELECT, DMA_ACKNOWLEDGE_N, TERMINAL_COUNT};
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            s1_r <= 6'h3A;
            s2_r <= 6'h3A;
            s3_r <= 6'h3A;
            ps_r <= 6'h3A;
        end
        else
        begin
            s1_r <= raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < 6; i++)
                if (s2_r[i] == s3_r[i])
                    ps_r[i] <= s3_r[i];
        end
    end
    logic cs_n_s, rd_n_s, wr_n_s, a0_s, dma_acknowledge_n_s, tc_s;
    assign {cs_n_s, rd_n_s, wr_n_s, a0_s, dma_acknowledge_n_s, tc_s} = ps_r;

    // Strobe edges; a held strobe counts once
    logic rd_q_r, wr_q_r;
    logic rd_act, wr_act, rd_fall, wr_fall;
    assign rd_act  = !rd_n_s && (!cs_n_s || !dma_acknowledge_n_s);
    assign wr_act  = !wr_n_s && (!cs_n_s || !dma_acknowledge_n_s);
    assign rd_fall = rd_act && !rd_q_r;
    assign wr_fall = wr_act && !wr_q_r;
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rd_q_r <= 1'b0;
            wr_q_r <= 1'b0;
        end
        else
        begin
            rd_q_r <= rd_act;
            wr_q_r <= wr_act;
        end
    end

    dchp_phase_e phase_r;
    logic [4:0]  op_r;
    logic [3:0]  pcnt_r, plen_r;
    logic [2:0]  rcnt_r, rlen_r;
    logic        ndma_r, wcmd_r, byte_rdy_r;
    logic [7:0]  st0_r, data_r, fill_r;
    logic [15:0] dly_r, pace_r;
    logic        tc_hit;

    logic data_rd, data_wr, dma_xfer;
    assign data_rd  = rd_fall && !cs_n_s && a0_s;
    assign data_wr  = wr_fall && !cs_n_s && a0_s;
    assign dma_xfer = (rd_fall || wr_fall) && !dma_acknowledge_n_s;
    assign tc_hit   = tc_s && phase_r == DCHP_EXEC;

    // Request flag blanking after each data register access
    always_ff @(posedge CLK)
    begin
        if (RST)
            dly_r <= 16'h0000;
        else if (data_rd || data_wr)
            dly_r <= SLOW_CLOCK_MODE ? 16'(`DCHP_REQ_DLY_SLOW_CYC)
                                     : 16'(`DCHP_REQ_DLY_FAST_CYC);
        else if (dly_r != 16'h0000)
            dly_r <= dly_r - 16'h0001;
    end

    // Phase sequencing; opcode decides parameter and result counts
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            phase_r <= DCHP_CMD;
            op_r    <= 5'h00;
            pcnt_r  <= 4'h0;
            plen_r  <= 4'h0;
            rcnt_r  <= 3'h0;
            rlen_r  <= 3'h0;
            ndma_r  <= 1'b0;
            wcmd_r  <= 1'b0;
            st0_r   <= `DCHP_ST0_RESET;
            fill_r  <= `DCHP_FILL_BYTE_RESET;
            DRIVE_SELECT <= 2'h0;
        end
        else
        begin
            unique case (phase_r)
                DCHP_CMD:
                    if (data_wr && dly_r == 16'h0000)
                    begin
                        if (pcnt_r == 4'h0)
                        begin
                            op_r   <= DB_IN[4:0];
                            wcmd_r <= DB_IN[4:0] == `DCHP_OP_WRITE_DATA
                                   || DB_IN[4:0] == `DCHP_OP_FORMAT;
                            ndma_r <= 1'b1;   // No specify here: polled mode
                            unique case (DB_IN[4:0])
                                `DCHP_OP_READ_DATA, `DCHP_OP_WRITE_DATA:
                                begin
                                    plen_r <= `DCHP_READ_DATA_PARAMS;
                                    rlen_r <= `DCHP_RW_RESULTS;
                                    pcnt_r <= 4'h1;
                                end
                                `DCHP_OP_FORMAT:
                                begin
                                    plen_r <= `DCHP_FORMAT_PARAMS;
                                    rlen_r <= `DCHP_RW_RESULTS;
                                    pcnt_r <= 4'h1;
                                end
                                `DCHP_OP_RECAL:
                                begin
                                    plen_r <= `DCHP_RECAL_PARAMS;
                                    rlen_r <= 3'h0;
                                    pcnt_r <= 4'h1;
                                end
                                default:
                                begin
                                    // Invalid code: one result byte only
                                    st0_r   <= `DCHP_ST0_INVALID;
                                    rlen_r  <= 3'h1;
                                    rcnt_r  <= 3'h0;
                                    phase_r <= DCHP_RES;
                                end
                            endcase
                        end
                        else
                        begin
                            if (pcnt_r == 4'h1)
                                DRIVE_SELECT <= DB_IN[1:0];
                            if (op_r == `DCHP_OP_FORMAT && pcnt_r == 4'h5)
                                fill_r <= DB_IN;
                            if (pcnt_r == plen_r - 4'h1)
                            begin
                                pcnt_r  <= 4'h0;
                                phase_r <= DCHP_EXEC;
                            end
                            else
                                pcnt_r <= pcnt_r + 4'h1;
                        end
                    end
                DCHP_EXEC:
                    if (op_r == `DCHP_OP_RECAL)
                    begin
                        st0_r   <= `DCHP_ST0_SEEK_END | {6'h00, DRIVE_SELECT};
                        rlen_r  <= `DCHP_RECAL_RESULTS;
                        rcnt_r  <= 3'h0;
                        phase_r <= DCHP_RES;
                    end
                    else if (tc_hit)
                    begin
                        st0_r   <= {6'h00, DRIVE_SELECT};
                        rcnt_r  <= 3'h0;
                        phase_r <= DCHP_RES;
                    end
                DCHP_RES:
                    if (data_rd && dly_r == 16'h0000)
                    begin
                        if (rcnt_r == rlen_r - 3'h1)
                        begin
                            phase_r <= DCHP_CMD;
                            ndma_r  <= 1'b0;
                        end
                        else
                            rcnt_r <= rcnt_r + 3'h1;
                    end
            endcase
        end
    end

    // Drive-side byte pacer; a transferred byte frees the slot
    always_ff @(posedge CLK)
    begin
        if (RST || phase_r != DCHP_EXEC)
        begin
            pace_r     <= 16'h0000;
            byte_rdy_r <= 1'b0;
        end
        else if (byte_rdy_r && (ndma_r ? (wcmd_r ? data_wr : data_rd) : dma_xfer))
            byte_rdy_r <= 1'b0;
        else if (pace_r == 16'(`DCHP_BYTE_PERIOD_CYC - 1))
        begin
            pace_r     <= 16'h0000;
            byte_rdy_r <= 1'b1;
        end
        else
            pace_r <= pace_r + 16'h0001;
    end

    // Interrupt level: per byte in polled mode, and on result entry from execution
    always_ff @(posedge CLK)
    begin
        if (RST)
            INT_REQ <= 1'b0;
        else if (phase_r == DCHP_EXEC && (tc_hit || op_r == `DCHP_OP_RECAL))
            INT_REQ <= 1'b1;
        else if (phase_r == DCHP_RES && data_rd)
            INT_REQ <= 1'b0;
        else if (phase_r == DCHP_EXEC && ndma_r)
            INT_REQ <= byte_rdy_r && !(wcmd_r ? data_wr : data_rd);
    end

    // DMA request drops on acknowledge low
    always_ff @(posedge CLK)
    begin
        if (RST)
            DMA_REQUEST <= 1'b0;
        else
            DMA_REQUEST <= phase_r == DCHP_EXEC && !ndma_r && byte_rdy_r
                        && dma_acknowledge_n_s;
    end

    // Status and read data; result bytes only in result phase
    dchp_msr_s msr;
    logic      req;
    assign req = dly_r == 16'h0000
              && (phase_r != DCHP_EXEC || (ndma_r && byte_rdy_r));
    assign msr = '{req: req, dir: phase_r == DCHP_RES || (phase_r == DCHP_EXEC && !wcmd_r),
                   ndma: phase_r == DCHP_EXEC && ndma_r,
                   busy: phase_r != DCHP_CMD || pcnt_r != 4'h0, drv_busy: 4'h0};
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            MAIN_STATUS <= 8'h00;
            DB_OUT      <= 8'h00;
            data_r      <= 8'h00;
        end
        else
        begin
            MAIN_STATUS <= msr;
            data_r      <= data_r + 8'h01;   // Stand-in for drive read data
            if (rd_act)
                DB_OUT <= DB_OUT;   // Byte stands for the whole read, not the next one
            else if (phase_r == DCHP_RES)
                DB_OUT <= rcnt_r == 3'h0 ? st0_r : 8'h00;
            else if (phase_r == DCHP_EXEC)
                DB_OUT <= data_r;
            else
                DB_OUT <= 8'h00;
            if (!cs_n_s && !a0_s)
                DB_OUT <= msr;
        end
    end
    assign DB_OE = rd_act;
    assign HEAD_RETRACT = phase_r == DCHP_EXEC && op_r == `DCHP_OP_RECAL;
    assign TRACK_WRITE  = phase_r == DCHP_EXEC && op_r == `DCHP_OP_FORMAT;
    assign WRITE_BYTE   = fill_r;

    // Checks
    req_blank_a: assert property (@(posedge CLK) disable iff (RST)
        (data_rd || data_wr) |=> !req [*8]) else $error("request flag not blanked");
    drq_drop_a: assert property (@(posedge CLK) disable iff (RST)
        !dma_acknowledge_n_s |=> !DMA_REQUEST) else $error("DMA request held under acknowledge");
    dma_noint_a: assert property (@(posedge CLK) disable iff (RST)
        phase_r == DCHP_EXEC && !ndma_r && !tc_hit |=> !$rose(INT_REQ)) else $error("interrupt in DMA");
    res_int_a: assert property (@(posedge CLK) disable iff (RST)
        tc_hit |=> INT_REQ && phase_r == DCHP_RES) else $error("no result interrupt");
    res_clr_a: assert property (@(posedge CLK) disable iff (RST)
        phase_r == DCHP_RES && data_rd |=> !INT_REQ) else $error("result interrupt not cleared");
    res_lock_a: assert property (@(posedge CLK) disable iff (RST)
        phase_r == DCHP_RES && !data_rd |=> phase_r == DCHP_RES) else $error("result left early");
    dir_res_a: assert property (@(posedge CLK) disable iff (RST)
        phase_r == DCHP_RES |-> msr.dir) else $error("direction wrong in result");
    int_hold_a: assert property (@(posedge CLK) disable iff (RST)
        phase_r == DCHP_RES && INT_REQ && !data_rd |=> INT_REQ) else $error("interrupt dropped");

endmodule // dchp_engine
`default_nettype wire

// ---- dchp_host_model.sv ----
// Processor-side partner of the phase engine: status polling, strobes, terminal count.
// Assumes the engine synchronizes and filters every control pin this model drives; the data bus is taken unsynchronized.
`timescale 1ns/1ps
`default_nettype none
module dchp_host_model
    import dchp_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic [7:0] MAIN_STATUS,
    input  wire logic [7:0] DB_OUT,
    output logic            CS_N,
    output logic            RD_N,
    output logic            WR_N,
    output logic            REGISTER_SELECT,
    output logic      [7:0] DB_IN,
    output logic            DMA_ACKNOWLEDGE_N,
    output logic            TERMINAL_COUNT
);
    dchp_hbus_s bus      = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [7:0] rd_data  = 8'h00;
    int         timeouts = 0;
    event       rd_done;

    // Pins follow the bus struct; non-DMA only, so acknowledge rests high
    assign CS_N              = bus.sel_n;
    assign RD_N              = bus.rd_n;
    assign WR_N              = bus.wr_n;
    assign REGISTER_SELECT   = bus.a0;
    assign DMA_ACKNOWLEDGE_N = 1'b1; // Polled mode: no DMA cycles to answer
    initial DB_IN = 8'hA5;
    initial TERMINAL_COUNT = 1'b0;

    // Bounded wait for request high with the wanted direction
    task automatic poll(input logic dir);
        int n;
        n = 0;
        while (!(MAIN_STATUS[7] === 1'b1 && MAIN_STATUS[6] === dir) && n < 3000)
        begin
            @(negedge CLK);
            n++;
        end
        if (n >= 3000) timeouts++;
    endtask

    // Held 8 cycles so the filter sees it whole; data or status register
    task automatic strobe(input logic rd, input logic [7:0] b, input logic a0, input logic sel_n);
        @(negedge CLK);
        DB_IN = b;
        bus = '{sel_n, !rd, rd, a0};
        repeat (8) @(negedge CLK);
        rd_data = DB_OUT;
        bus = '{1'b1, 1'b1, 1'b1, 1'b0};
        DB_IN = ~b; // Released bus shows no stale value
    endtask

    // Command bytes in caller order, written unchanged; callers may leave don't-care bits set
    task automatic wr(input logic [7:0] b);
        poll(1'b0);
        strobe(1'b0, b, 1'b1, 1'b0);
    endtask

    task automatic rd();
        poll(1'b1);
        strobe(1'b1, 8'h00, 1'b1, 1'b0);
        -> rd_done;
    endtask

    // System ends any transfer by terminal count
    task automatic tc();
        @(negedge CLK);
        TERMINAL_COUNT = 1'b1;
        repeat (8) @(negedge CLK);
        TERMINAL_COUNT = 1'b0;
    endtask
endmodule // dchp_host_model
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the phase engine with a processor partner.
// Assumes the 40 MHz clock and the blanking and byte pacing figures of the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "dchp_regs.svh"
module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        slow = 1'b0;
    logic        cs_n, rd_n, wr_n, sel, dma_acknowledge_n, tcnt, db_oe, int_req, dreq, retract, trk_wr;
    logic [7:0]  db_in, db_out, msr, wbyte;
    logic [1:0]  drv;
    logic [15:0] exp_q[$]; // Notes of {mask, value}
    logic [15:0] note;
    logic [7:0]  fill;
    logic        retract_seen = 1'b0;
    int          err_count = 0;
    int          checked = 0;
    int          n;

    always #12.5 clk = ~clk;

    dchp_engine dchp_engine_i (.CLK(clk), .RST(rst), .SLOW_CLOCK_MODE(slow), .CS_N(cs_n), .RD_N(rd_n),
        .WR_N(wr_n), .REGISTER_SELECT(sel), .DB_IN(db_in), .DB_OUT(db_out), .DB_OE(db_oe), .INT_REQ(int_req),
        .DMA_REQUEST(dreq), .DMA_ACKNOWLEDGE_N(dma_acknowledge_n), .TERMINAL_COUNT(tcnt), .MAIN_STATUS(msr),
        .DRIVE_SELECT(drv), .HEAD_RETRACT(retract), .TRACK_WRITE(trk_wr), .WRITE_BYTE(wbyte));
    dchp_host_model dchp_host_model_i (.CLK(clk), .MAIN_STATUS(msr), .DB_OUT(db_out), .CS_N(cs_n),
        .RD_N(rd_n), .WR_N(wr_n), .REGISTER_SELECT(sel), .DB_IN(db_in), .DMA_ACKNOWLEDGE_N(dma_acknowledge_n),
        .TERMINAL_COUNT(tcnt));

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Each result read takes the oldest note off the queue
    always @(dchp_host_model_i.rd_done)
    begin
        note = exp_q.pop_front();
        check("result byte", note[7:0], dchp_host_model_i.rd_data & note[15:8]);
    end

    // Head retract lasts one cycle; remember that it was seen
    always @(negedge clk)
        if (retract === 1'b1)
            retract_seen = 1'b1;

    task automatic end_of_test();
        err_count += dchp_host_model_i.timeouts;
        $display("Comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Counts request-low cycles left after a data write
    task automatic blank(input int cyc);
        n = 0;
        while (msr[7] !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check("blanking", 8'h01, 8'(n >= cyc - 12 && n <= cyc));
    endtask

    task automatic wait_int();
        n = 0;
        while (int_req !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        check("interrupt", 8'h01, 8'(int_req));
    endtask

    // Execution bytes without polling, each cleared by its own strobe
    task automatic exec_bytes(input logic is_wr, input int cnt);
        repeat (cnt)
        begin
            wait_int();
            check("ndma bit", 8'h01, 8'(msr[5]));
            check("no dma request", 8'h00, 8'(dreq));
            dchp_host_model_i.strobe(!is_wr, 8'h5A, 1'b1, 1'b0);
            repeat (2) @(negedge clk);
            check("int cleared", 8'h00, 8'(int_req));
        end
    endtask

    // Terminal count, then result interrupt and 7 result bytes
    task automatic finish_rw(input logic refuse);
        dchp_host_model_i.tc();
        dchp_host_model_i.poll(1'b1);
        check("result int", 8'h01, 8'(int_req));
        check("ndma ended", 8'h00, 8'(msr[5]));
        exp_q.push_back(16'hFC00);
        repeat (6) exp_q.push_back(16'hFF00);
        dchp_host_model_i.rd();
        check("int after first", 8'h00, 8'(int_req));
        if (refuse) dchp_host_model_i.strobe(1'b0, 8'h07, 1'b1, 1'b0);
        repeat (6) dchp_host_model_i.rd();
        dchp_host_model_i.poll(1'b0);
        check("idle busy", 8'h00, 8'(msr[4]));
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        n = $urandom(32'hF926);
        // Deselected write is ignored; status byte readable over the data bus
        dchp_host_model_i.strobe(1'b0, 8'h07, 1'b1, 1'b1);
        dchp_host_model_i.strobe(1'b1, 8'h00, 1'b0, 1'b0);
        check("status byte", 8'h80, dchp_host_model_i.rd_data);
        $display("test status read done");
        // Invalid opcode gives one result byte
        dchp_host_model_i.wr(8'h1F);
        blank(`DCHP_REQ_DLY_FAST_CYC);
        exp_q.push_back({8'hFF, `DCHP_ST0_INVALID});
        dchp_host_model_i.rd();
        $display("test invalid opcode done");
        // Recalibrate at the half-rate blanking
        slow = !slow;
        fill = 8'($urandom % 4);
        dchp_host_model_i.wr(8'h07);
        blank(`DCHP_REQ_DLY_SLOW_CYC);
        dchp_host_model_i.wr(fill);
        wait_int();
        check("drive select", fill, 8'(drv));
        check("head retract", 8'h01, 8'(retract_seen));
        exp_q.push_back({8'hE0, `DCHP_ST0_SEEK_END});
        exp_q.push_back(16'hFF00);
        repeat (2) dchp_host_model_i.rd();
        slow = !slow;
        $display("test recalibrate done");
        // Read data, result phase refuses a new opcode
        dchp_host_model_i.wr(8'h46);
        repeat (8) dchp_host_model_i.wr(8'($urandom));
        exec_bytes(1'b0, 3);
        finish_rw(1'b1);
        $display("test read data done");
        dchp_host_model_i.wr(8'h45);
        repeat (8) dchp_host_model_i.wr(8'($urandom));
        exec_bytes(1'b1, 2);
        finish_rw(1'b0);
        $display("test write data done");
        // Format: track write with the chosen fill
        fill = 8'($urandom);
        dchp_host_model_i.wr(8'h4D);
        dchp_host_model_i.wr(8'h01);
        dchp_host_model_i.wr(8'h02);
        dchp_host_model_i.wr(8'h08);
        dchp_host_model_i.wr(8'h1B);
        dchp_host_model_i.wr(fill);
        repeat (20) @(negedge clk);
        check("track write", 8'h01, 8'(trk_wr));
        check("fill byte", fill, wbyte);
        finish_rw(1'b0);
        $display("test format done");
        end_of_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (100000) @(posedge clk);
        err_count++;
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
